// file: hw/fbws_top.sv
// flash byte write sequencer: register slave, unlock, block write cache, flash request
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fbws_regs.svh"
module fbws_top (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [15:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output var fbws_pkg::fbws_prog_t flash_req,
    input wire logic flash_done,
    output var fbws_pkg::fbws_xram_t xram_req
);
    fbws_pkg::fbws_top_state_t s;
    fbws_pkg::fbws_top_state_t next_s;

    logic key_unlocked;
    logic key_half;
    logic key_wr;
    logic key_consume;
    logic cache_valid;
    logic [14:0] cache_addr;
    logic [7:0] cache_data;
    logic cache_store;
    logic cache_drop;

    logic ext_sel;
    logic [14:0] ext_addr;
    logic wr_ext;
    logic flash_target;
    logic pair_hit;
    logic need_prog;
    logic accept_wr;
    logic reg_wr;
    logic [31:0] rd_mux;

    // upper half of the address map is the external-move space
    assign ext_sel = address[`FBWS_EXT_BIT];
    assign ext_addr = address[14:0];
    assign wr_ext = write && ext_sel && byteenable[0];
    // erase mode belongs to the page erase logic, so byte writes are not taken then
    assign flash_target = s.program_store_write_enable && !s.program_store_erase_enable;
    assign pair_hit = cache_valid && (ext_addr == cache_addr + 15'h0001);
    assign need_prog = wr_ext && flash_target && key_unlocked
        && (!s.blk_en || pair_hit);

    // a programming write is held off until the flash reports done, so the
    // unlock is consumed at commit, except by a cached first block byte, which uses it at once
    assign waitrequest = (read && !s.rd_ack)
        || (need_prog && s.fsm != fbws_pkg::FBWS_ST_FINISH);
    assign accept_wr = write && !waitrequest;
    assign reg_wr = accept_wr && !ext_sel && byteenable[0];

    assign key_wr = reg_wr && address == `FBWS_OFF_UNLOCK_KEY;
    // a cached first byte uses up its unlock too, so the second byte needs its own pair
    assign key_consume = accept_wr && wr_ext && flash_target && key_unlocked;
    assign cache_store = key_consume && s.blk_en && !pair_hit;
    // leaving block mode throws the lone first byte away unwritten
    assign cache_drop = !s.blk_en || (key_consume && pair_hit);

    fbws_key_unlock u_key (
        .sys_clk(sys_clk),
        .rst(rst),
        .key_wr(key_wr),
        .key_data(writedata[7:0]),
        .consume(key_consume),
        .unlocked(key_unlocked),
        .half(key_half)
    );

    fbws_byte_cache u_cache (
        .sys_clk(sys_clk),
        .rst(rst),
        .store(cache_store),
        .drop(cache_drop),
        .store_addr(ext_addr),
        .store_data(writedata[7:0]),
        .valid(cache_valid),
        .addr(cache_addr),
        .data(cache_data)
    );

    // status shows unlock progress so software can see why a byte was refused
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (address)
            `FBWS_OFF_PROG_CTRL: begin
                rd_mux[`FBWS_BIT_WRITE_EN] = s.program_store_write_enable;
                rd_mux[`FBWS_BIT_ERASE_EN] = s.program_store_erase_enable;
            end
            `FBWS_OFF_CACHE_CTRL: begin
                rd_mux[`FBWS_BIT_BLOCK_EN] = s.blk_en;
            end
            `FBWS_OFF_STATUS: begin
                rd_mux[0] = key_unlocked;
                rd_mux[1] = key_half;
                rd_mux[2] = cache_valid;
                rd_mux[3] = (s.fsm != fbws_pkg::FBWS_ST_IDLE);
                rd_mux[15:8] = s.ign_cnt;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        next_s = s;
        next_s.prog.start = 1'b0;
        next_s.xram.wr = 1'b0;

        // one wait cycle on reads so read data always come from a register
        if (read && !s.rd_ack) begin
            next_s.rd_ack = 1'b1;
            next_s.rdata = rd_mux;
        end else begin
            next_s.rd_ack = 1'b0;
        end

        if (reg_wr && address == `FBWS_OFF_PROG_CTRL) begin
            next_s.program_store_write_enable = writedata[`FBWS_BIT_WRITE_EN];
            next_s.program_store_erase_enable = writedata[`FBWS_BIT_ERASE_EN];
        end
        if (reg_wr && address == `FBWS_OFF_CACHE_CTRL) begin
            next_s.blk_en = writedata[`FBWS_BIT_BLOCK_EN];
        end

        if (accept_wr && wr_ext && !s.program_store_write_enable) begin
            next_s.xram.wr = 1'b1;
            next_s.xram.addr = ext_addr;
            next_s.xram.data = writedata[7:0];
        end
        // the count wraps; software compares two readings, not an absolute value
        if (accept_wr && wr_ext && flash_target && !key_unlocked) begin
            next_s.ign_cnt = s.ign_cnt + 8'h01;
        end

        // finish lets the held bus write complete once before the next start
        unique case (s.fsm)
            fbws_pkg::FBWS_ST_IDLE: begin
                if (need_prog) begin
                    next_s.fsm = fbws_pkg::FBWS_ST_WAIT;
                    next_s.prog.start = 1'b1;
                    // a pair goes out as one operation, lower byte from the cache
                    next_s.prog.pair = s.blk_en;
                    if (s.blk_en) begin
                        next_s.prog.addr = cache_addr;
                        next_s.prog.data = {writedata[7:0], cache_data};
                    end else begin
                        next_s.prog.addr = ext_addr;
                        next_s.prog.data = {8'h00, writedata[7:0]};
                    end
                end
            end
            fbws_pkg::FBWS_ST_WAIT: begin
                if (flash_done) begin
                    next_s.fsm = fbws_pkg::FBWS_ST_FINISH;
                end
            end
            fbws_pkg::FBWS_ST_FINISH: begin
                next_s.fsm = fbws_pkg::FBWS_ST_IDLE;
            end
            default: begin
                next_s.fsm = fbws_pkg::FBWS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s <= '{fsm: fbws_pkg::FBWS_ST_IDLE, rdata: `FBWS_RST_WORD, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign readdata = s.rdata;
    assign flash_req = s.prog;
    assign xram_req = s.xram;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_prog_after_unlock: assert property (
        flash_req.start |-> $past(key_unlocked) && $past(wr_ext))
        else $error("flash program started without a keyed external write");
    a_locked_write_ignored: assert property (
        (accept_wr && wr_ext && flash_target && !key_unlocked)
            |=> !flash_req.start && !xram_req.wr)
        else $error("unkeyed program write was not ignored");
    a_xram_route: assert property (
        (accept_wr && wr_ext && !s.program_store_write_enable)
            |=> xram_req.wr && xram_req.addr == $past(ext_addr))
        else $error("external write not routed to data memory");
    a_no_xram_flash: assert property (
        (accept_wr && wr_ext && s.program_store_write_enable) |=> !xram_req.wr)
        else $error("external write leaked to data memory while flash targeted");
    a_block_enable_bit: assert property (
        (reg_wr && address == `FBWS_OFF_CACHE_CTRL)
            |=> s.blk_en == $past(writedata[0]))
        else $error("block write enable not taken from bit 0");
    a_pair_one_op: assert property (
        flash_req.start |=> !flash_req.start && s.fsm == fbws_pkg::FBWS_ST_WAIT)
        else $error("pair commit issued more than one flash operation");
    a_cache_first_held: assert property (
        cache_store |=> !flash_req.start && cache_valid)
        else $error("first block byte not held in cache");
    a_pair_data_order: assert property (
        (flash_req.start && flash_req.pair)
            |-> flash_req.addr == cache_addr && flash_req.data[7:0] == cache_data)
        else $error("pair commit does not carry the cached first byte");
    a_cache_dropped: assert property (
        !s.blk_en |=> !cache_valid)
        else $error("cached byte survived leaving block mode");

    // unlock sequence seen from the bus side
    a_key_first_half: assert property (
        (key_wr && writedata[7:0] == `FBWS_KEY_FIRST) |=> key_half)
        else $error("first key code did not arm the unlock");
    a_key_bad_code: assert property (
        (key_wr && writedata[7:0] != `FBWS_KEY_FIRST && writedata[7:0] != `FBWS_KEY_SECOND)
            |=> !key_half && !key_unlocked)
        else $error("unexpected key code left the unlock armed");
    a_locked_no_start: assert property (
        !key_unlocked |=> !flash_req.start)
        else $error("flash program started while locked");
    a_busy_no_consume: assert property (
        s.fsm == fbws_pkg::FBWS_ST_WAIT |-> !key_consume)
        else $error("unlock consumed before the flash finished");
    a_ign_count: assert property (
        (accept_wr && wr_ext && flash_target && !key_unlocked)
            |=> s.ign_cnt == $past(s.ign_cnt) + 8'h01)
        else $error("ignored write not counted");

    // content of each flash operation
    a_start_from_idle: assert property (
        flash_req.start |-> $past(s.fsm) == fbws_pkg::FBWS_ST_IDLE)
        else $error("flash program started while an operation was open");
    a_start_pulse: assert property (
        flash_req.start |=> !flash_req.start ##1 !flash_req.start)
        else $error("flash program start longer than one cycle");
    a_single_upper_zero: assert property (
        (flash_req.start && !flash_req.pair) |-> flash_req.data[15:8] == 8'h00)
        else $error("single byte operation carries a second byte");
    a_single_target: assert property (
        (flash_req.start && !flash_req.pair) |-> flash_req.addr == $past(ext_addr)
            && flash_req.data[7:0] == $past(writedata[7:0]))
        else $error("single byte operation has the wrong address or data");
    a_erase_no_prog: assert property (
        (wr_ext && s.program_store_erase_enable) |=> !flash_req.start)
        else $error("byte program started with erase enable set");

    // control bits and routing
    a_write_enable_bit: assert property (
        (reg_wr && address == `FBWS_OFF_PROG_CTRL)
            |=> s.program_store_write_enable == $past(writedata[`FBWS_BIT_WRITE_EN]))
        else $error("write enable not taken from its control bit");
    a_xram_data: assert property (
        (accept_wr && wr_ext && !s.program_store_write_enable)
            |=> xram_req.data == $past(writedata[7:0]))
        else $error("data memory write carries the wrong byte");
    a_xram_only_ext: assert property (
        !(accept_wr && wr_ext) |=> !xram_req.wr)
        else $error("data memory write without an external write");
    a_block_read_back: assert property (
        (read && !s.rd_ack && address == `FBWS_OFF_CACHE_CTRL)
            |=> readdata[`FBWS_BIT_BLOCK_EN] == $past(s.blk_en))
        else $error("block write enable does not read back");

    // block write pairing
    a_blk_first_no_op: assert property (
        (s.blk_en && !pair_hit) |=> !flash_req.start)
        else $error("lone first block byte reached the flash");
    a_pair_upper_byte: assert property (
        (flash_req.start && flash_req.pair) |-> flash_req.data[15:8] == $past(writedata[7:0])
            && $past(ext_addr) == flash_req.addr + 15'h0001)
        else $error("pair commit carries the wrong second byte");
    a_commit_drops_cache: assert property (
        (key_consume && pair_hit) |=> !cache_valid)
        else $error("cache still valid after its pair was committed");
    a_commit_needs_pair: assert property (
        flash_req.start |-> $past(!s.blk_en || pair_hit))
        else $error("block mode committed without a second byte");

    c_single_commit: cover property (flash_req.start && !flash_req.pair);
    c_pair_commit: cover property (flash_req.start && flash_req.pair);
    c_locked_ignored: cover property (accept_wr && wr_ext && flash_target && !key_unlocked);
    c_cache_drop: cover property (cache_valid ##1 !s.blk_en);
    c_key_restart: cover property (key_wr && key_unlocked);
endmodule
`default_nettype wire

// file: pkg/fbws_regs.svh
// register offsets, field positions and key codes of the flash byte write sequencer
`ifndef FBWS_REGS_SVH
`define FBWS_REGS_SVH

`define FBWS_OFF_PROG_CTRL 16'h0000
`define FBWS_OFF_UNLOCK_KEY 16'h0004
`define FBWS_OFF_CACHE_CTRL 16'h0008
`define FBWS_OFF_STATUS 16'h000C
`define FBWS_EXT_BIT 15
`define FBWS_BIT_WRITE_EN 0
`define FBWS_BIT_ERASE_EN 1
`define FBWS_BIT_BLOCK_EN 0
`define FBWS_KEY_FIRST 8'hA5
`define FBWS_KEY_SECOND 8'hF1
`define FBWS_PAGE_BYTES 512
`define FBWS_RST_WORD 32'h0000_0000

`endif

// file: pkg/fbws_pkg.sv
// types shared by the flash byte write sequencer modules
`default_nettype none
package fbws_pkg;

    typedef enum logic [1:0] {
        FBWS_KEY_LOCKED = 2'b00,
        FBWS_KEY_HALF = 2'b01,
        FBWS_KEY_OPEN = 2'b10
    } fbws_key_t;

    typedef enum logic [1:0] {
        FBWS_ST_IDLE = 2'b00,
        FBWS_ST_WAIT = 2'b01,
        FBWS_ST_FINISH = 2'b10
    } fbws_fsm_t;

    // one flash program operation: one byte, or a pair at addr and addr+1
    typedef struct packed {
        logic start;
        logic pair;
        logic [14:0] addr;
        logic [15:0] data;
    } fbws_prog_t;

    // external data memory write when the program store write enable is clear
    typedef struct packed {
        logic wr;
        logic [14:0] addr;
        logic [7:0] data;
    } fbws_xram_t;

    typedef struct packed {
        fbws_key_t st;
    } fbws_key_state_t;

    typedef struct packed {
        logic valid;
        logic [14:0] addr;
        logic [7:0] data;
    } fbws_cache_state_t;

    typedef struct packed {
        fbws_fsm_t fsm;
        logic program_store_write_enable;
        logic program_store_erase_enable;
        logic blk_en;
        logic rd_ack;
        logic [31:0] rdata;
        logic [7:0] ign_cnt;
        fbws_prog_t prog;
        fbws_xram_t xram;
    } fbws_top_state_t;

endpackage
`default_nettype wire

// file: hw/fbws_key_unlock.sv
// two-code unlock sequencer guarding each flash byte write
`timescale 1ns/1ps
`default_nettype none
`include "fbws_regs.svh"
module fbws_key_unlock (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic key_wr,
    input wire logic [7:0] key_data,
    input wire logic consume,
    output logic unlocked,
    output logic half
);
    fbws_pkg::fbws_key_state_t s;
    fbws_pkg::fbws_key_state_t next_s;

    always_comb begin
        next_s = s;
        if (consume) begin
            next_s.st = fbws_pkg::FBWS_KEY_LOCKED;
        end else if (key_wr) begin
            // any code out of order restarts the sequence from the first code
            if (s.st == fbws_pkg::FBWS_KEY_HALF && key_data == `FBWS_KEY_SECOND) begin
                next_s.st = fbws_pkg::FBWS_KEY_OPEN;
            end else if (key_data == `FBWS_KEY_FIRST) begin
                next_s.st = fbws_pkg::FBWS_KEY_HALF;
            end else begin
                next_s.st = fbws_pkg::FBWS_KEY_LOCKED;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s <= '{st: fbws_pkg::FBWS_KEY_LOCKED};
        end else begin
            s <= next_s;
        end
    end

    assign unlocked = (s.st == fbws_pkg::FBWS_KEY_OPEN);
    assign half = (s.st == fbws_pkg::FBWS_KEY_HALF);

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_key_open_order: assert property (
        $rose(unlocked) |-> $past(key_wr && key_data == `FBWS_KEY_SECOND && half))
        else $error("unlock opened without first then second code");
    a_key_consumed: assert property (
        consume |=> !unlocked ##1 !unlocked)
        else $error("unlock not consumed by a byte write");
endmodule
`default_nettype wire

// file: hw/fbws_byte_cache.sv
// one-byte holding cache for the first byte of a block write pair
`timescale 1ns/1ps
`default_nettype none
module fbws_byte_cache (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic store,
    input wire logic drop,
    input wire logic [14:0] store_addr,
    input wire logic [7:0] store_data,
    output logic valid,
    output logic [14:0] addr,
    output logic [7:0] data
);
    fbws_pkg::fbws_cache_state_t s;
    fbws_pkg::fbws_cache_state_t next_s;

    always_comb begin
        next_s = s;
        if (store) begin
            next_s.valid = 1'b1;
            next_s.addr = store_addr;
            next_s.data = store_data;
        end else if (drop) begin
            next_s.valid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign valid = s.valid;
    assign addr = s.addr;
    assign data = s.data;
endmodule
`default_nettype wire

// file: testbench/fbws_flash_model.sv
// flash macro model: answers each program request after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module fbws_flash_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire fbws_pkg::fbws_prog_t flash_req,
    input wire logic [3:0] lat,
    output logic flash_done,
    output logic [7:0] n_ops,
    output var fbws_pkg::fbws_prog_t last_op
);
    logic [3:0] cnt;
    logic busy;
    always @(posedge sys_clk) begin
        if (rst) begin
            flash_done <= 1'b0;
            busy <= 1'b0;
            cnt <= 4'h0;
            n_ops <= 8'h00;
            last_op <= '0;
        end else if (flash_req.start === 1'b1) begin
            // a pair costs one program cycle, the same as a single byte
            flash_done <= 1'b0;
            busy <= 1'b1;
            cnt <= lat;
            n_ops <= n_ops + 8'h01;
            last_op <= flash_req;
        end else if (busy && cnt == 4'h0) begin
            busy <= 1'b0;
            flash_done <= 1'b1;
        end else begin
            flash_done <= 1'b0;
            if (busy) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the flash byte write sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fbws_regs.svh"
module testbench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] address = 16'h0000;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0] byteenable = 4'hF;
    logic [3:0] lat = 4'h2;
    logic [31:0] readdata;
    logic waitrequest;
    logic flash_done;
    logic [7:0] n_ops;
    logic [7:0] n0;
    logic [31:0] q;
    fbws_pkg::fbws_prog_t flash_req;
    fbws_pkg::fbws_prog_t last_op;
    fbws_pkg::fbws_xram_t xram_req;
    fbws_pkg::fbws_xram_t xr_last;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    int dur = 0;
    int sdur = 0;
    int n_xr = 0;
    logic [7:0] ign = 8'h00;
    localparam logic [15:0] EXT = 16'h8000;
    // whole run needs well under a thousand cycles
    localparam int CYC_LIMIT = 5000;

    fbws_top u_dut (.sys_clk, .rst, .address, .read, .write, .writedata, .byteenable,
        .readdata, .waitrequest, .flash_req, .flash_done, .xram_req);
    fbws_flash_model u_flash (.sys_clk, .rst, .flash_req, .lat, .flash_done, .n_ops,
        .last_op);

    always #50 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (xram_req.wr === 1'b1) begin
            n_xr <= n_xr + 1;
            xr_last <= xram_req;
        end
    end

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one bus cycle; the request stands until waitrequest is seen low at a rising edge,
    // read data are taken at that edge and only then is the request released
    task automatic bus(input logic rd, input logic [15:0] a, input logic [31:0] d);
        int t0;
        @(posedge sys_clk);
        t0 = cyc;
        address <= a;
        writedata <= d;
        read <= rd;
        write <= !rd;
        do begin
            @(posedge sys_clk);
        end while (waitrequest !== 1'b0);
        q = readdata;
        dur = cyc - t0;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        bus(1'b0, a, d);
    endtask

    task automatic rd(input logic [15:0] a);
        bus(1'b1, a, 32'h0000_0000);
    endtask

    // pages are taken as freshly erased: the flash model keeps no erase state
    // the bench has no interrupt source, so no key sequence is ever split
    task automatic prog(input logic [14:0] a, input logic [7:0] d);
        wr(`FBWS_OFF_UNLOCK_KEY, {24'h000000, `FBWS_KEY_FIRST});
        wr(`FBWS_OFF_UNLOCK_KEY, {24'h000000, `FBWS_KEY_SECOND});
        wr(EXT | {1'b0, a}, {24'h000000, d});
    endtask

    task automatic t_reset();
        logic [15:0] offs [5];
        offs = '{16'h0000, 16'h0004, 16'h0008, 16'h000C, 16'h0010};
        foreach (offs[i]) begin
            rd(offs[i]);
            chk(q, `FBWS_RST_WORD);
        end
        $display("test reset done");
    endtask

    task automatic t_single();
        wr(`FBWS_OFF_PROG_CTRL, 32'h0000_0001);
        n0 = n_ops;
        prog(15'h0123, 8'h5A);
        sdur = dur;
        chk(n_ops, n0 + 8'h01);
        chk({last_op.pair, last_op.addr, last_op.data}, {1'b0, 15'h0123, 16'h005A});
        // the unlock is used up, so a second write is refused
        wr(EXT | 16'h0124, 32'h0000_0077);
        ign++;
        chk(n_ops, n0 + 8'h01);
        wr(`FBWS_OFF_UNLOCK_KEY, {24'h000000, `FBWS_KEY_SECOND});
        wr(`FBWS_OFF_UNLOCK_KEY, {24'h000000, `FBWS_KEY_FIRST});
        wr(EXT | 16'h0125, 32'h0000_0066);
        ign++;
        chk(n_ops, n0 + 8'h01);
        rd(`FBWS_OFF_STATUS);
        chk(q[15:8], ign);
        lat <= 4'h9;
        prog(15'h0126, 8'h44);
        chk(dur, sdur + 7);
        lat <= 4'h2;
        $display("test single done");
    endtask

    task automatic t_block();
        wr(`FBWS_OFF_CACHE_CTRL, 32'h0000_0001);
        n0 = n_ops;
        prog(15'h0200, 8'h11);
        chk(n_ops, n0);
        rd(`FBWS_OFF_STATUS);
        chk(q[2], 1'b1);
        prog(15'h0201, 8'h22);
        chk(n_ops, n0 + 8'h01);
        chk(dur, sdur);
        chk({last_op.pair, last_op.addr, last_op.data}, {1'b1, 15'h0200, 16'h2211});
        prog(15'h0300, 8'h33);
        wr(`FBWS_OFF_PROG_CTRL, 32'h0000_0000);
        wr(`FBWS_OFF_CACHE_CTRL, 32'h0000_0000);
        rd(`FBWS_OFF_STATUS);
        chk(q[2], 1'b0);
        chk(n_ops, n0 + 8'h01);
        $display("test block done");
    endtask

    task automatic t_route();
        int x0;
        n0 = n_ops;
        x0 = n_xr;
        prog(15'h0040, 8'h99);
        repeat (2) @(posedge sys_clk);
        chk(n_xr, x0 + 1);
        chk({xr_last.addr, xr_last.data}, {15'h0040, 8'h99});
        chk(n_ops, n0);
        wr(`FBWS_OFF_PROG_CTRL, 32'h0000_0003);
        prog(15'h0041, 8'h55);
        repeat (2) @(posedge sys_clk);
        chk(n_ops, n0);
        chk(n_xr, x0 + 1);
        rd(`FBWS_OFF_STATUS);
        chk(q[15:8], ign);
        $display("test route done");
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        fork
            begin
                t_reset();
                t_single();
                t_block();
                t_route();
            end
            begin
                wait (cyc >= CYC_LIMIT);
                n_mismatch++;
                $display("timeout at %0t after %0d cycles", $time, cyc);
            end
        join_any
        print_verdict();
    end
endmodule
`default_nettype wire
